// ---- hdl/ladder_edge_latch_compare.sv ----
`timescale 1ns/100ps
`default_nettype none

// Operation
// - ORed coil: any true rung drives point
// - Inversion complements rung status at position
// - Rising coil on one scan per rise
// - Start rising contact closed one scan
// - Start falling contact closed one scan
// - Parallel edge contacts ORed with rung
// - Series edge contacts ANDed with rung
// - Set latches point range on
// - Reset latches point range off
// - Bit latch on sets word bit
// - Bit latch off clears word bit
// - Start equal compare opens rung
// - Start unequal compare opens rung
// - Parallel equal compare ORed with rung
// - Parallel unequal compare ORed with rung
module ladder_edge_latch_compare (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic instr_valid,
   output logic instr_ready,
   input wire ladder_pkg::instr_t instr,
   input wire logic scan_end,
   input wire ladder_pkg::pt_wr_t pt_wr,
   input wire ladder_pkg::word_wr_t word_wr,
   input wire logic [ladder_pkg::PT_W-1:0] pt_rd_addr,
   output logic pt_rd_data,
   input wire logic [ladder_pkg::WA_W-1:0] word_rd_addr,
   output logic [ladder_pkg::WORD_W-1:0] word_rd_data,
   output logic rung_status
);

   typedef enum logic {ST_IDLE, ST_RANGE} state_t;

   state_t state_reg, state_next;
   logic [ladder_pkg::NPTS-1:0] img_reg, img_next;
   logic [ladder_pkg::NPTS-1:0] prev_reg, prev_next;
   logic [ladder_pkg::NPTS-1:0] coil_reg, coil_next;
   logic [ladder_pkg::NPTS-1:0] orseen_reg, orseen_next;
   logic [ladder_pkg::WORD_W-1:0] wmem_reg [ladder_pkg::NWORDS];
   logic [ladder_pkg::WORD_W-1:0] wmem_next [ladder_pkg::NWORDS];
   logic rung_reg, rung_next;
   logic [ladder_pkg::PT_W-1:0] rptr_reg, rptr_next;
   logic [ladder_pkg::PT_W-1:0] rend_reg, rend_next;
   logic rval_reg, rval_next;
   logic pt_rd_reg;
   logic [ladder_pkg::WORD_W-1:0] word_rd_reg;
   logic take, cur, old, rise_val, fall_val, eq_val;
   logic [ladder_pkg::WORD_W-1:0] b_val, a_val;

   // -------------------------------------------------------------
   // Operand fetch
   // -------------------------------------------------------------
   // Second compare operand from a word, through a pointer, or constant
   function automatic logic [ladder_pkg::WORD_W-1:0] fetch_b(
      input ladder_pkg::opnd_kind_t kind,
      input logic [ladder_pkg::WORD_W-1:0] b,
      input logic [ladder_pkg::WORD_W-1:0] direct,
      input logic [ladder_pkg::WORD_W-1:0] indirect);
      unique case (kind)
         ladder_pkg::OPND_WORD: fetch_b = direct;
         ladder_pkg::OPND_POINTER: fetch_b = indirect;
         ladder_pkg::OPND_CONST: fetch_b = b;
         default: fetch_b = b;
      endcase
   endfunction

   // Edge detection compares the image with the last scan's copy
   always_comb begin
      take = instr_valid && instr_ready;
      cur = img_reg[instr.pt];
      old = prev_reg[instr.pt];
      rise_val = cur && !old;
      fall_val = !cur && old;
      a_val = wmem_reg[instr.wa];
      b_val = fetch_b(instr.kind, instr.b,
         wmem_reg[instr.b[ladder_pkg::WA_W-1:0]],
         wmem_reg[wmem_reg[instr.b[ladder_pkg::WA_W-1:0]]
            [ladder_pkg::WA_W-1:0]]);
      eq_val = (a_val == b_val);
   end

   // -------------------------------------------------------------
   // Next-state logic
   // -------------------------------------------------------------
   // Range latches walk one point a cycle; ready drops meanwhile,
   // which trades speed for a single write port on the image.
   always_comb begin
      state_next = state_reg;
      img_next = img_reg;
      prev_next = prev_reg;
      coil_next = coil_reg;
      orseen_next = orseen_reg;
      wmem_next = wmem_reg;
      rung_next = rung_reg;
      rptr_next = rptr_reg;
      rend_next = rend_reg;
      rval_next = rval_reg;
      instr_ready = (state_reg == ST_IDLE);
      if (word_wr.en) begin
         wmem_next[word_wr.wa] = word_wr.data;
      end
      if (pt_wr.en) begin
         img_next[pt_wr.pt] = pt_wr.val;
      end
      unique case (state_reg)
         ST_IDLE: begin
            if (take) begin
               unique case (instr.op)
                  ladder_pkg::OR_COIL: begin
                     // First reference this scan replaces, later ones OR
                     img_next[instr.pt] = rung_reg ||
                        (orseen_reg[instr.pt] && img_reg[instr.pt]);
                     orseen_next[instr.pt] = 1'b1;
                  end
                  ladder_pkg::RUNG_INVERT:
                     rung_next = !rung_reg;
                  ladder_pkg::RISING_ONE_SHOT_COIL: begin
                     img_next[instr.pt] = rung_reg &&
                        !coil_reg[instr.pt];
                     coil_next[instr.pt] = rung_reg;
                  end
                  ladder_pkg::START_RISING_EDGE_CONTACT:
                     rung_next = rise_val;
                  ladder_pkg::START_FALLING_EDGE_CONTACT:
                     rung_next = fall_val;
                  ladder_pkg::PARALLEL_RISING_EDGE_CONTACT:
                     rung_next = rung_reg || rise_val;
                  ladder_pkg::PARALLEL_FALLING_EDGE_CONTACT:
                     rung_next = rung_reg || fall_val;
                  ladder_pkg::SERIES_RISING_EDGE_CONTACT:
                     rung_next = rung_reg && rise_val;
                  ladder_pkg::SERIES_FALLING_EDGE_CONTACT:
                     rung_next = rung_reg && fall_val;
                  ladder_pkg::LATCH_SET,
                  ladder_pkg::LATCH_RESET: begin
                     // A false rung leaves the latched points alone
                     if (rung_reg) begin
                        img_next[instr.pt] =
                           (instr.op == ladder_pkg::LATCH_SET);
                        if (instr.pt_end > instr.pt) begin
                           rptr_next = instr.pt + 1'b1;
                           rend_next = instr.pt_end;
                           rval_next = (instr.op == ladder_pkg::LATCH_SET);
                           state_next = ST_RANGE;
                        end
                     end
                  end
                  ladder_pkg::WORD_BIT_LATCH_ON:
                     if (rung_reg) begin
                        wmem_next[instr.wa][instr.bit_sel] = 1'b1;
                     end
                  ladder_pkg::WORD_BIT_LATCH_OFF:
                     if (rung_reg) begin
                        wmem_next[instr.wa][instr.bit_sel] = 1'b0;
                     end
                  ladder_pkg::START_EQUAL_COMPARE:
                     rung_next = eq_val;
                  ladder_pkg::START_UNEQUAL_COMPARE:
                     rung_next = !eq_val;
                  ladder_pkg::PARALLEL_EQUAL_COMPARE:
                     rung_next = rung_reg || eq_val;
                  ladder_pkg::PARALLEL_UNEQUAL_COMPARE:
                     rung_next = rung_reg || !eq_val;
                  default: ;
               endcase
            end
         end
         ST_RANGE: begin
            img_next[rptr_reg] = rval_reg;
            rptr_next = rptr_reg + 1'b1;
            if (rptr_reg == rend_reg) begin
               state_next = ST_IDLE;
            end
         end
      endcase
      // Scan boundary: snapshot image for edges, restart OR coils
      if (scan_end) begin
         prev_next = img_reg;
         orseen_next = '0;
      end
   end

   // -------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= ST_IDLE;
         img_reg <= ladder_pkg::IMG_RESET;
         prev_reg <= ladder_pkg::IMG_RESET;
         coil_reg <= ladder_pkg::IMG_RESET;
         orseen_reg <= ladder_pkg::IMG_RESET;
         for (int i = 0; i < ladder_pkg::NWORDS; i++) begin
            wmem_reg[i] <= ladder_pkg::WORD_RESET;
         end
         rung_reg <= 1'b0;
         rptr_reg <= '0;
         rend_reg <= '0;
         rval_reg <= 1'b0;
         pt_rd_reg <= 1'b0;
         word_rd_reg <= ladder_pkg::WORD_RESET;
      end else begin
         state_reg <= state_next;
         img_reg <= img_next;
         prev_reg <= prev_next;
         coil_reg <= coil_next;
         orseen_reg <= orseen_next;
         wmem_reg <= wmem_next;
         rung_reg <= rung_next;
         rptr_reg <= rptr_next;
         rend_reg <= rend_next;
         rval_reg <= rval_next;
         pt_rd_reg <= img_reg[pt_rd_addr];
         word_rd_reg <= wmem_reg[word_rd_addr];
      end
   end

   assign pt_rd_data = pt_rd_reg;
   assign word_rd_data = word_rd_reg;
   assign rung_status = rung_reg;

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   // Opcode strobes as plain nets, so every property sees sampled values
   // rather than a function reading live state after the clock edge
   localparam int N_OPS = 17;
   logic [N_OPS-1:0] op_hit;

   for (genvar g = 0; g < N_OPS; g++) begin : g_op_hit
      assign op_hit[g] = take && (instr.op == ladder_pkg::op_t'(g));
   end

   a_or_coil_on: assert property (
      op_hit[ladder_pkg::OR_COIL] && rung_reg && !pt_wr.en
      |=> img_reg[$past(instr.pt)])
      else $error("ORed coil not driven on");
   a_invert_rung: assert property (
      op_hit[ladder_pkg::RUNG_INVERT] |=> rung_reg != $past(rung_reg))
      else $error("Rung not inverted");
   a_one_shot_off: assert property (
      op_hit[ladder_pkg::RISING_ONE_SHOT_COIL] && coil_reg[instr.pt]
      |=> !img_reg[$past(instr.pt)])
      else $error("One shot held past one scan");
   a_start_rise: assert property (
      op_hit[ladder_pkg::START_RISING_EDGE_CONTACT]
      |=> rung_reg == ($past(cur) && !$past(old)))
      else $error("Start rising contact wrong");
   a_start_fall: assert property (
      op_hit[ladder_pkg::START_FALLING_EDGE_CONTACT]
      |=> rung_reg == (!$past(cur) && $past(old)))
      else $error("Start falling contact wrong");
   a_par_fall: assert property (
      op_hit[ladder_pkg::PARALLEL_FALLING_EDGE_CONTACT] && !rung_reg
      |=> rung_reg == $past(fall_val))
      else $error("Parallel falling contact wrong");
   a_ser_rise: assert property (
      op_hit[ladder_pkg::SERIES_RISING_EDGE_CONTACT]
      |=> rung_reg == ($past(rung_reg) && $past(cur) && !$past(old)))
      else $error("Series rising contact wrong");
   a_set_range: assert property (
      op_hit[ladder_pkg::LATCH_SET] && rung_reg && instr.pt_end > instr.pt
      && instr.pt_end == instr.pt + 11'h003 |=> !instr_ready [*3]
      ##1 instr_ready && img_reg[$past(instr.pt, 4) + 11'h003])
      else $error("Set range not completed");
   a_reset_point: assert property (
      op_hit[ladder_pkg::LATCH_RESET] && rung_reg && !pt_wr.en
      |=> !img_reg[$past(instr.pt)])
      else $error("Reset left point on");
   a_bit_on: assert property (
      op_hit[ladder_pkg::WORD_BIT_LATCH_ON] && rung_reg && !word_wr.en
      |=> wmem_reg[$past(instr.wa)][$past(instr.bit_sel)])
      else $error("Word bit not set");
   a_bit_off: assert property (
      op_hit[ladder_pkg::WORD_BIT_LATCH_OFF] && rung_reg && !word_wr.en
      |=> !wmem_reg[$past(instr.wa)][$past(instr.bit_sel)])
      else $error("Word bit not cleared");
   a_start_eq: assert property (
      op_hit[ladder_pkg::START_EQUAL_COMPARE]
      |=> rung_reg == ($past(a_val) == $past(b_val)))
      else $error("Equal compare wrong");
   a_start_ne: assert property (
      op_hit[ladder_pkg::START_UNEQUAL_COMPARE]
      |=> rung_reg == ($past(a_val) != $past(b_val)))
      else $error("Unequal compare wrong");
   a_par_eq: assert property (
      op_hit[ladder_pkg::PARALLEL_EQUAL_COMPARE]
      |=> rung_reg == ($past(rung_reg) || $past(a_val) == $past(b_val)))
      else $error("Parallel equal compare wrong");
   a_par_ne: assert property (
      op_hit[ladder_pkg::PARALLEL_UNEQUAL_COMPARE]
      |=> rung_reg == ($past(rung_reg) || $past(a_val) != $past(b_val)))
      else $error("Parallel unequal compare wrong");
   a_prev_snap: assert property (
      scan_end |=> prev_reg == $past(img_reg))
      else $error("Previous image not captured");

   c_range_set: cover property (op_hit[ladder_pkg::LATCH_SET] && rung_reg
      && instr.pt_end > instr.pt);
   c_rise_closed: cover property (
      op_hit[ladder_pkg::START_RISING_EDGE_CONTACT] && rise_val);
   c_or_coil_twice: cover property (op_hit[ladder_pkg::OR_COIL]
      && orseen_reg[instr.pt]);
   c_ptr_compare: cover property (
      op_hit[ladder_pkg::START_EQUAL_COMPARE]
      && instr.kind == ladder_pkg::OPND_POINTER && eq_val);

endmodule

`default_nettype wire

// ---- hdl/ladder_pkg.sv ----
package ladder_pkg;

   // -------------------------------------------------------------
   // Sizes of the discrete image and the word memory
   // -------------------------------------------------------------
   localparam int PT_W = 11;
   localparam int NPTS = 2048;
   localparam int WA_W = 8;
   localparam int NWORDS = 256;
   localparam int WORD_W = 16;
   localparam int BIT_W = 4;
   localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
   localparam logic [NPTS-1:0] IMG_RESET = '0;

   // -------------------------------------------------------------
   // Instruction codes and operand kinds
   // -------------------------------------------------------------
   typedef enum logic [4:0] {
      OR_COIL, RUNG_INVERT, RISING_ONE_SHOT_COIL,
      START_RISING_EDGE_CONTACT, START_FALLING_EDGE_CONTACT,
      PARALLEL_RISING_EDGE_CONTACT, PARALLEL_FALLING_EDGE_CONTACT,
      SERIES_RISING_EDGE_CONTACT, SERIES_FALLING_EDGE_CONTACT,
      LATCH_SET, LATCH_RESET, WORD_BIT_LATCH_ON, WORD_BIT_LATCH_OFF,
      START_EQUAL_COMPARE, START_UNEQUAL_COMPARE,
      PARALLEL_EQUAL_COMPARE, PARALLEL_UNEQUAL_COMPARE
   } op_t;

   typedef enum logic [1:0] {
      OPND_WORD, OPND_POINTER, OPND_CONST
   } opnd_kind_t;

   // One instruction step as issued by the scan sequencer
   typedef struct packed {
      op_t op;
      logic [PT_W-1:0] pt;
      logic [PT_W-1:0] pt_end;
      logic [WA_W-1:0] wa;
      opnd_kind_t kind;
      logic [WORD_W-1:0] b;
      logic [BIT_W-1:0] bit_sel;
   } instr_t;

   // Write from the I/O update into the point image
   typedef struct packed {
      logic en;
      logic [PT_W-1:0] pt;
      logic val;
   } pt_wr_t;

   // Write from the I/O or host side into word memory
   typedef struct packed {
      logic en;
      logic [WA_W-1:0] wa;
      logic [WORD_W-1:0] data;
   } word_wr_t;

endpackage

// ---- tb/ladder_edge_latch_compare_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module ladder_edge_latch_compare_tb;
   // -------------------------------------------------------------
   // Stimulus, mirrors and counters
   // -------------------------------------------------------------
   localparam logic [7:0] ZW = 8'hff; // Word left at zero, forces rung
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic instr_valid = 1'b0;
   logic instr_ready;
   ladder_pkg::instr_t instr = '0;
   logic scan_end = 1'b0;
   ladder_pkg::pt_wr_t pt_wr = '0;
   ladder_pkg::word_wr_t word_wr = '0;
   logic [ladder_pkg::PT_W-1:0] pt_rd_addr = '0;
   logic pt_rd_data;
   logic [ladder_pkg::WA_W-1:0] word_rd_addr = '0;
   logic [ladder_pkg::WORD_W-1:0] word_rd_data;
   logic rung_status;
   int error_cnt = 0;
   int n_checks = 0;
   logic er = 1'b0; // Expected rung
   logic [15:0] wmem [256]; // Mirror of word memory
   logic [15:0] cur = '0; // Points 0..15 now and at last scan end
   logic [15:0] prev = '0;

   ladder_edge_latch_compare i_ladder_edge_latch_compare (
      .ref_clk(ref_clk), .nrst(nrst), .instr_valid(instr_valid),
      .instr_ready(instr_ready), .instr(instr), .scan_end(scan_end),
      .pt_wr(pt_wr), .word_wr(word_wr), .pt_rd_addr(pt_rd_addr),
      .pt_rd_data(pt_rd_data), .word_rd_addr(word_rd_addr),
      .word_rd_data(word_rd_data), .rung_status(rung_status));

   // Free-running 25 MHz clock
   initial forever #20 ref_clk = ~ref_clk;

   // -------------------------------------------------------------
   // Drivers, readers and comparisons
   // -------------------------------------------------------------
   // Inputs always move 1 ns after the rising edge
   task automatic step;
      @(posedge ref_clk);
      #1;
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Leading edge keeps valid from being lowered and raised in one step
   task automatic ex(input ladder_pkg::op_t op, input logic [10:0] pt,
         input logic [10:0] pe = '0, input logic [7:0] wa = '0,
         input ladder_pkg::opnd_kind_t k = ladder_pkg::OPND_CONST,
         input logic [15:0] b = '0, input logic [3:0] bs = '0);
      step;
      instr = '{op, pt, pe, wa, k, b, bs};
      instr_valid = 1'b1;
      while (instr_ready !== 1'b1) step;
      step;
      instr_valid = 1'b0;
   endtask
   task automatic wpt(input logic [10:0] p, input logic v);
      pt_wr = '{1'b1, p, v};
      step;
      pt_wr.en = 1'b0;
      step;
   endtask
   task automatic wwd(input logic [7:0] wa, input logic [15:0] d);
      word_wr = '{1'b1, wa, d};
      step;
      word_wr.en = 1'b0;
      step;
      wmem[wa] = d;
   endtask
   // Scan end also snapshots the mirror, as the design does its image
   task automatic scan;
      scan_end = 1'b1;
      step;
      scan_end = 1'b0;
      step;
      prev = cur;
   endtask
   task automatic rpt(input logic [10:0] p, output logic v);
      pt_rd_addr = p;
      step;
      v = pt_rd_data;
   endtask
   task automatic rwd(input logic [7:0] w, output logic [15:0] d);
      word_rd_addr = w;
      step;
      d = word_rd_data;
   endtask
   task automatic set_rung(input logic v);
      ex(ladder_pkg::START_EQUAL_COMPARE, '0, '0, ZW,
         ladder_pkg::OPND_CONST, {15'h0, ~v});
      er = v;
   endtask
   // Points a-1 .. a+4 against mask bits 0..5
   task automatic chk_rng(input logic [10:0] a, input logic [5:0] m);
      logic v;
      for (int j = 0; j < 6; j++) begin
         rpt(a + 11'(j) - 11'h1, v);
         chk_bit(v, m[j]);
      end
   endtask
   task automatic coil(input int o, input logic [10:0] t, input logic r,
         input logic e);
      logic v;
      set_rung(r);
      ex(ladder_pkg::op_t'(o), t);
      rpt(t, v);
      chk_bit(v, e);
   endtask
   // Rung after one instruction, by enum position of the opcode
   function automatic logic rexp(int o, logic r, logic eq, logic rs,
         logic fl);
      case (o)
         1: return ~r;
         3: return rs;
         4: return fl;
         5: return r | rs;
         6: return r | fl;
         7: return r & rs;
         8: return r & fl;
         13: return eq;
         14: return ~eq;
         15: return r | eq;
         default: return r | ~eq;
      endcase
   endfunction
   task automatic tally_and_finish;
      $display("checks=%0d errors=%0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // Watchdog: the tests need about 800 cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      error_cnt++;
      tally_and_finish;
   end

   // -------------------------------------------------------------
   // Test sequence
   // -------------------------------------------------------------
   initial begin
      int o, k;
      logic v;
      logic [3:0] p;
      logic [7:0] wa;
      logic [10:0] a;
      logic [15:0] d, b, opv;
      void'($urandom(32'ha2a6e8c8));
      foreach (wmem[x]) wmem[x] = '0;
      repeat (2) @(posedge ref_clk);
      chk_bit(instr_ready, 1'b1);
      chk_bit(rung_status, 1'b0);
      #1 nrst = 1'b1;
      // Random mix of edges, compares, inversion and image traffic
      for (int i = 0; i < 300; i++) begin
         p = 4'($urandom_range(0, 15));
         case ($urandom_range(0, 5))
            0: begin
               v = 1'($urandom_range(0, 1));
               wpt({7'h0, p}, v);
               cur[p] = v;
            end
            1: scan;
            2: begin
               wa = 8'($urandom_range(0, 7));
               d = $urandom_range(0, 1) ? 16'($urandom)
                  : 16'($urandom_range(0, 3));
               wwd(wa, d);
            end
            3: begin
               o = $urandom_range(3, 8);
               ex(ladder_pkg::op_t'(o), {7'h0, p});
               er = rexp(o, er, 1'b0, cur[p] & ~prev[p], ~cur[p] & prev[p]);
               if (o < 5) chk_bit(rung_status, er);
               else chk_bit(rung_status, er);
            end
            default: begin
               o = $urandom_range(12, 16);
               if (o == 12) o = 1;
               k = $urandom_range(0, 2);
               wa = 8'($urandom_range(0, 7));
               b = 16'($urandom_range(0, 7));
               if (k == 2 && $urandom_range(0, 1)) b = wmem[wa];
               opv = k == 2 ? b : k == 0 ? wmem[b[7:0]]
                  : wmem[wmem[b[7:0]][7:0]];
               ex(ladder_pkg::op_t'(o), '0, '0, wa,
                  ladder_pkg::opnd_kind_t'(k), b);
               er = rexp(o, er, wmem[wa] == opv, 1'b0, 1'b0);
               if (o == 1) chk_bit(rung_status, er);
               else if (o < 15) chk_bit(rung_status, er);
               else chk_bit(rung_status, er);
            end
         endcase
      end
      // Range latches; a false rung must leave points alone. Set targets
      // stay on plain relay points, never timers, counters or real inputs.
      a = 11'($urandom_range(100, 2000));
      set_rung(1'b1);
      ex(ladder_pkg::LATCH_SET, a, a + 11'h3);
      chk_bit(instr_ready, 1'b0);
      set_rung(1'b0);
      ex(ladder_pkg::LATCH_RESET, a, a + 11'h3);
      chk_rng(a, 6'b011110);
      set_rung(1'b1);
      ex(ladder_pkg::LATCH_RESET, a + 11'h1, a + 11'h1);
      set_rung(1'b0);
      chk_rng(a, 6'b011010);
      set_rung(1'b1);
      ex(ladder_pkg::LATCH_RESET, a, a + 11'h3);
      chk_rng(a, 6'b000000);
      ex(ladder_pkg::LATCH_SET, a + 11'h2, a);
      chk_rng(a, 6'b001000);
      // Bit latches on one word, bit 0 and bit 15 first
      wwd(8'h20, 16'($urandom));
      for (int i = 0; i < 20; i++) begin
         v = 1'($urandom_range(0, 1));
         o = $urandom_range(11, 12);
         b = i < 2 ? 16'(i * 15) : 16'($urandom_range(0, 15));
         set_rung(v);
         ex(ladder_pkg::op_t'(o), '0, '0, 8'h20, ladder_pkg::OPND_CONST,
            '0, b[3:0]);
         if (v) wmem[32][b[3:0]] = (o == 11);
         rwd(8'h20, d);
         chk_word(d, wmem[32]);
      end
      // ORed coil: later rungs OR in, a new scan starts over
      scan;
      coil(0, a + 11'd10, 1'b0, 1'b0);
      coil(0, a + 11'd10, 1'b1, 1'b1);
      coil(0, a + 11'd10, 1'b0, 1'b1);
      scan;
      coil(0, a + 11'd10, 1'b0, 1'b0);
      // One-shot coil: on for the scan of the rise only
      coil(2, a + 11'd12, 1'b0, 1'b0);
      scan;
      coil(2, a + 11'd12, 1'b1, 1'b1);
      scan;
      coil(2, a + 11'd12, 1'b1, 1'b0);
      coil(2, a + 11'd12, 1'b0, 1'b0);
      coil(2, a + 11'd12, 1'b1, 1'b1);
      tally_and_finish;
   end
endmodule
`default_nettype wire
